// ===== core/bnkrf_defines.vh
// Constants for the banked system register file.
`ifndef BNKRF_DEFINES_VH
`define BNKRF_DEFINES_VH
`define BNKRF_A_PORT2_MODE    8'hf6
`define BNKRF_A_PORT3_MODE    8'hf7
`define BNKRF_A_PORT01_MODE   8'hf8
`define BNKRF_A_INT_PRIO      8'hf9
`define BNKRF_A_INT_REQ       8'hfa
`define BNKRF_A_INT_MASK      8'hfb
`define BNKRF_A_FLAGS         8'hfc
`define BNKRF_A_POINTER       8'hfd
`define BNKRF_A_SP_HIGH       8'hfe
`define BNKRF_A_SP_LOW        8'hff
`define BNKRF_BANK_0          4'h0
`define BNKRF_BANK_D          4'hd
`define BNKRF_BANK_F          4'hf
`define BNKRF_O_PORT_A        4'h0
`define BNKRF_O_PORT_B        4'h1
`define BNKRF_O_PORT_C        4'h2
`define BNKRF_O_PORT_D        4'h3
`define BNKRF_O_CTR8          4'h0
`define BNKRF_O_CTR_SHARED    4'h1
`define BNKRF_O_CTR16         4'h2
`define BNKRF_O_CTR_EXTRA     4'h3
`define BNKRF_O_RLD8_LOW      4'h4
`define BNKRF_O_RLD8_HIGH     4'h5
`define BNKRF_O_RLD16_LOW     4'h6
`define BNKRF_O_RLD16_HIGH    4'h7
`define BNKRF_O_CAP16_LOW     4'h8
`define BNKRF_O_CAP16_HIGH    4'h9
`define BNKRF_O_CAP8_LOW      4'ha
`define BNKRF_O_CAP8_HIGH     4'hb
`define BNKRF_O_LVD           4'hc
`define BNKRF_O_PORT_CONFIG   4'h0
`define BNKRF_O_STOP_REC      4'hb
`define BNKRF_O_STOP_REC_B    4'hd
`define BNKRF_O_WDOG_MODE     4'hf
`define BNKRF_RST_ZERO        8'h00
`define BNKRF_RST_CTR_EXTRA   8'h1f
`define BNKRF_RST_PORT01_MODE 8'hcf
`define BNKRF_KEEP_CTR8       8'h3e
`define BNKRF_KEEP_CTR_SHARED 8'h30
`define BNKRF_KEEP_CTR16      8'h3c
`define BNKRF_UNDEF_READ      8'hff
`define BNKRF_VEC_RESET       4'hc
`endif

// ===== core/bnkrf_top.v
// Banked system register file with stop-mode recovery handling.
`timescale 1ns/1ps
`include "bnkrf_defines.vh"
module bnkrf_top (
   input  wire       sys_clk_i,
   input  wire       arst_n_i,
   input  wire       clk_en_i,
   input  wire       stop_recovery_i,
   input  wire [7:0] addr_i,
   input  wire [7:0] wdata_i,
   input  wire       wr_i,
   input  wire       rd_i,
   input  wire [2:0] vector_sel_i,
   input  wire       vector_reset_i,
   output reg  [7:0] rdata_o,
   output reg  [3:0] work_group_o,
   output reg  [3:0] bank_sel_o,
   output reg  [7:0] counter8_control_o,
   output reg  [7:0] shared_timer_control_o,
   output reg  [7:0] counter16_control_o,
   output reg  [7:0] timer_control_extra_o,
   output reg  [7:0] port0_port1_mode_o,
   output reg  [3:0] vector_addr_o
);
   reg  [7:0] port_data_r [0:3];
   reg  [7:0] bank_d_r [0:12];
   reg  [7:0] port_config_r;
   reg  [7:0] stop_recovery_ctrl_r;
   reg  [7:0] stop_recovery_ctrl_b_r;
   reg  [7:0] watchdog_mode_r;
   reg  [7:0] ctl_r [0:9];
   reg  [7:0] rdata_nxt;
   reg        wr_ok;
   integer    i;

   // Low 16 addresses go to the selected bank; 0xf6 to 0xff go to the control block, the rest read 0xff.
   function is_low;
      input [7:0] a;
      begin
         is_low = (a[7:4] == 4'h0);
      end
   endfunction

   // A stop recovery keeps the masked bits and reloads the rest from reset.
   function [7:0] recover;
      input [7:0] cur;
      input [7:0] keep;
      input [7:0] rst;
      begin
         recover = (cur & keep) | (rst & ~keep);
      end
   endfunction

   wire [3:0] bank   = ctl_r[7][3:0];
   wire [3:0] off    = addr_i[3:0];
   wire       in_ctl = (addr_i >= `BNKRF_A_PORT2_MODE);
   wire [3:0] cidx   = addr_i[3:0] - 4'h6;

   always @* begin
      rdata_nxt = `BNKRF_UNDEF_READ;
      wr_ok = 1'b0;
      if (is_low(addr_i)) begin
         case (bank)
            `BNKRF_BANK_0: begin
               if (off <= `BNKRF_O_PORT_D) begin
                  rdata_nxt = port_data_r[off[1:0]];
                  wr_ok = 1'b1;
               end
            end
            `BNKRF_BANK_D: begin
               if (off <= `BNKRF_O_LVD) begin
                  rdata_nxt = bank_d_r[off];
                  wr_ok = 1'b1;
               end
            end
            `BNKRF_BANK_F: begin
               wr_ok = 1'b1;
               case (off)
                  `BNKRF_O_PORT_CONFIG: rdata_nxt = port_config_r;
                  `BNKRF_O_STOP_REC:    rdata_nxt = stop_recovery_ctrl_r;
                  `BNKRF_O_STOP_REC_B:  rdata_nxt = stop_recovery_ctrl_b_r;
                  `BNKRF_O_WDOG_MODE:   rdata_nxt = watchdog_mode_r;
                  default:              wr_ok = 1'b0;
               endcase
            end
            default: wr_ok = 1'b0;
         endcase
      end else if (in_ctl) begin
         rdata_nxt = ctl_r[cidx];
         wr_ok = 1'b1;
      end
   end

   always @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (i = 0; i < 4; i = i + 1) begin
            port_data_r[i] <= `BNKRF_RST_ZERO;
         end
         for (i = 0; i < 13; i = i + 1) begin
            bank_d_r[i] <= `BNKRF_RST_ZERO;
         end
         bank_d_r[`BNKRF_O_CTR_EXTRA] <= `BNKRF_RST_CTR_EXTRA;
         for (i = 0; i < 10; i = i + 1) begin
            ctl_r[i] <= `BNKRF_RST_ZERO;
         end
         ctl_r[2] <= `BNKRF_RST_PORT01_MODE;
         port_config_r <= `BNKRF_RST_ZERO;
         stop_recovery_ctrl_r <= `BNKRF_RST_ZERO;
         stop_recovery_ctrl_b_r <= `BNKRF_RST_ZERO;
         watchdog_mode_r <= `BNKRF_RST_ZERO;
         rdata_o <= `BNKRF_RST_ZERO;
         work_group_o <= 4'h0;
         bank_sel_o <= 4'h0;
         counter8_control_o <= `BNKRF_RST_ZERO;
         shared_timer_control_o <= `BNKRF_RST_ZERO;
         counter16_control_o <= `BNKRF_RST_ZERO;
         timer_control_extra_o <= `BNKRF_RST_CTR_EXTRA;
         port0_port1_mode_o <= `BNKRF_RST_PORT01_MODE;
         vector_addr_o <= `BNKRF_VEC_RESET;
      end else if (clk_en_i) begin
         // Recovery has priority over a same-cycle write so the preserved set is exact.
         if (stop_recovery_i) begin
            // Reload pairs, capture pairs, second recovery control and port 2/3 modes hold; port 0/1 mode reloads.
            bank_d_r[`BNKRF_O_CTR8] <= recover(bank_d_r[`BNKRF_O_CTR8],
               `BNKRF_KEEP_CTR8, `BNKRF_RST_ZERO);
            bank_d_r[`BNKRF_O_CTR_SHARED] <= recover(bank_d_r[`BNKRF_O_CTR_SHARED],
               `BNKRF_KEEP_CTR_SHARED, `BNKRF_RST_ZERO);
            bank_d_r[`BNKRF_O_CTR16] <= recover(bank_d_r[`BNKRF_O_CTR16],
               `BNKRF_KEEP_CTR16, `BNKRF_RST_ZERO);
            bank_d_r[`BNKRF_O_CTR_EXTRA] <= `BNKRF_RST_CTR_EXTRA;
            ctl_r[7] <= `BNKRF_RST_ZERO;
            ctl_r[4] <= `BNKRF_RST_ZERO;
            ctl_r[2] <= `BNKRF_RST_PORT01_MODE;
         end else if (wr_i && wr_ok) begin
            if (is_low(addr_i)) begin
               if (bank == `BNKRF_BANK_0) begin
                  port_data_r[off[1:0]] <= wdata_i;
               end else if (bank == `BNKRF_BANK_D) begin
                  bank_d_r[off] <= wdata_i;
               end else begin
                  case (off)
                     `BNKRF_O_PORT_CONFIG: port_config_r <= wdata_i;
                     `BNKRF_O_STOP_REC:    stop_recovery_ctrl_r <= wdata_i;
                     `BNKRF_O_STOP_REC_B:  stop_recovery_ctrl_b_r <= wdata_i;
                     default:              watchdog_mode_r <= wdata_i;
                  endcase
               end
            end else begin
               ctl_r[cidx] <= wdata_i;
            end
         end
         rdata_o <= rd_i ? rdata_nxt : `BNKRF_RST_ZERO;
         work_group_o <= ctl_r[7][7:4];
         bank_sel_o <= ctl_r[7][3:0];
         counter8_control_o <= bank_d_r[`BNKRF_O_CTR8];
         shared_timer_control_o <= bank_d_r[`BNKRF_O_CTR_SHARED];
         counter16_control_o <= bank_d_r[`BNKRF_O_CTR16];
         timer_control_extra_o <= bank_d_r[`BNKRF_O_CTR_EXTRA];
         port0_port1_mode_o <= ctl_r[2];
         // Each source owns two bytes; the reset start follows the six pairs.
         vector_addr_o <= vector_reset_i ? `BNKRF_VEC_RESET : {vector_sel_i, 1'b0};
      end
   end
endmodule

// ===== verification/bnkrf_core.sv
// Core model issuing register reads and writes.
`timescale 1ns/1ps
module bnkrf_core (
   input  wire        sys_clk_i,
   output logic [7:0] addr_i = 8'h00, wdata_i = 8'h00,
   output logic       wr_i = 1'b0, rd_i = 1'b0
);
   logic [7:0] exp_q[$];
   // Strobes stay up between calls so back-to-back cycles never assign twice in one step.
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      addr_i <= a;
      wdata_i <= w ? d : ~d;
      wr_i <= w;
      rd_i <= !w;
      if (!w) exp_q.push_back(d);
      @(posedge sys_clk_i);
   endtask
   task automatic idle;
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask
endmodule

// ===== verification/bnkrf_properties.sv
// Port checker for the banked register file.
`timescale 1ns/1ps
module bnkrf_chk (
   input wire       sys_clk_i, arst_n_i, clk_en_i, stop_recovery_i, wr_i, rd_i, vector_reset_i,
   input wire [7:0] addr_i, wdata_i, rdata_o, counter8_control_o, shared_timer_control_o,
   input wire [7:0] counter16_control_o, timer_control_extra_o, port0_port1_mode_o,
   input wire [2:0] vector_sel_i,
   input wire [3:0] work_group_o, bank_sel_o, vector_addr_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   // A pointer write lands one edge later and shows on the nibble outputs one edge after that.
   wire ptr_wr = wr_i && clk_en_i && !stop_recovery_i && addr_i == 8'hfd;
   wire rec = stop_recovery_i && clk_en_i;
   property p_grp; ptr_wr ##1 clk_en_i |=> work_group_o == $past(wdata_i[7:4], 2); endproperty
   a_grp: assert property (p_grp) else $error("working group differs");
   property p_bank; ptr_wr ##1 clk_en_i |=> bank_sel_o == $past(wdata_i[3:0], 2); endproperty
   a_bank: assert property (p_bank) else $error("bank select differs");
   property p_rsv; rd_i && clk_en_i && addr_i inside {[8'hf0:8'hf5]} |=> rdata_o == 8'hff; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved read differs");
   property p_c8; rec ##1 clk_en_i |=> counter8_control_o == ($past(counter8_control_o) & 8'h3e);
   endproperty
   a_c8: assert property (p_c8) else $error("counter8 control differs");
   property p_csh; rec ##1 clk_en_i |=> shared_timer_control_o == ($past(shared_timer_control_o) & 8'h30);
   endproperty
   a_csh: assert property (p_csh) else $error("shared control differs");
   property p_c16; rec ##1 clk_en_i |=> counter16_control_o == ($past(counter16_control_o) & 8'h3c);
   endproperty
   a_c16: assert property (p_c16) else $error("counter16 control differs");
   property p_ext; rec ##1 clk_en_i |=> timer_control_extra_o == 8'h1f && port0_port1_mode_o == 8'hcf;
   endproperty
   a_ext: assert property (p_ext) else $error("recovery defaults differ");
   property p_vec; clk_en_i |=> vector_addr_o == ($past(vector_reset_i) ? 4'hc : $past({vector_sel_i, 1'b0}));
   endproperty
   a_vec: assert property (p_vec) else $error("vector address differs");
   property p_rdz; !rd_i && clk_en_i |=> rdata_o == 8'h00; endproperty
   a_rdz: assert property (p_rdz) else $error("idle read data differs");
endmodule
bind bnkrf_top bnkrf_chk i_chk (.*);

// ===== verification/bnkrf_top_tb.sv
// Self-checking bench for the banked register file.
`timescale 1ns/1ps
module bnkrf_top_tb;
   logic       sys_clk_i = 1'b0, arst_n_i = 1'b0, clk_en_i = 1'b1, stop_recovery_i = 1'b0;
   logic       vector_reset_i = 1'b0, rd_d = 1'b0;
   logic [2:0] vector_sel_i = 3'h0;
   wire  [7:0] addr_i, wdata_i, rdata_o, counter8_control_o, shared_timer_control_o;
   wire  [7:0] counter16_control_o, timer_control_extra_o, port0_port1_mode_o;
   wire  [3:0] work_group_o, bank_sel_o, vector_addr_o;
   wire        wr_i, rd_i;
   int         bad_count = 0, checked = 0, cyc = 0, i;
   logic [7:0] v[16], p, e;
   logic [3:0] offs[8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h0, 4'hb, 4'hd, 4'hf};
   bnkrf_core i_bnkrf_core (.*);
   bnkrf_top i_bnkrf_top (.*);
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task results;
      if (bad_count == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial forever #5 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      if (rd_d) chk("rdata", rdata_o, i_bnkrf_core.exp_q.pop_front());
      rd_d <= rd_i;
      if (++cyc == 3000) begin
         bad_count++;
         results();
      end
   end
   initial begin
      void'($urandom(32'h5343469e));
      repeat (3) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      chk("extra", timer_control_extra_o, 8'h1f);
      chk("p01", port0_port1_mode_o, 8'hcf);
      i_bnkrf_core.acc(0, 8'hfd, 8'h00);
      i_bnkrf_core.acc(0, 8'hf8, 8'hcf);
      i_bnkrf_core.acc(0, 8'hf3, 8'hff);
      i_bnkrf_core.acc(0, 8'h42, 8'hff);
      p = 8'h0d | (8'($urandom) & 8'hf0);
      i_bnkrf_core.acc(1, 8'hfd, p);
      i_bnkrf_core.acc(0, 8'h03, 8'h1f);
      i_bnkrf_core.idle();
      chk("group", {4'h0, work_group_o}, {4'h0, p[7:4]});
      chk("bank", {4'h0, bank_sel_o}, 8'h0d);
      for (i = 0; i < 12; i++) begin
         v[i] = $urandom;
         i_bnkrf_core.acc(1, i, v[i]);
      end
      for (i = 0; i < 12; i++) i_bnkrf_core.acc(0, i, v[i]);
      i_bnkrf_core.acc(1, 8'h0e, 8'h5a);
      i_bnkrf_core.acc(0, 8'h0e, 8'hff);
      i_bnkrf_core.idle();
      stop_recovery_i <= 1'b1;
      @(posedge sys_clk_i);
      stop_recovery_i <= 1'b0;
      i_bnkrf_core.acc(1, 8'hfd, 8'h0d);
      for (i = 0; i < 12; i++) begin
         e = i == 0 ? v[i] & 8'h3e : i == 1 ? v[i] & 8'h30 : i == 2 ? v[i] & 8'h3c : v[i];
         i_bnkrf_core.acc(0, i, i == 3 ? 8'h1f : e);
      end
      for (i = 0; i < 8; i++) begin
         if (i % 4 == 0) i_bnkrf_core.acc(1, 8'hfd, i == 0 ? 8'h00 : 8'h0f);
         v[i] = $urandom;
         i_bnkrf_core.acc(1, offs[i], v[i]);
         i_bnkrf_core.acc(0, offs[i], v[i]);
      end
      i_bnkrf_core.acc(1, 8'h01, 8'h33);
      i_bnkrf_core.acc(0, 8'h01, 8'hff);
      for (i = 246; i < 256; i++) begin
         v[0] = $urandom;
         if (i != 253) i_bnkrf_core.acc(1, i, v[0]);
         if (i != 253) i_bnkrf_core.acc(0, i, v[0]);
      end
      i_bnkrf_core.idle();
      for (i = 0; i < 7; i++) begin
         vector_sel_i <= i % 6;
         vector_reset_i <= i == 6;
         repeat (2) @(posedge sys_clk_i);
         chk("vector", {4'h0, vector_addr_o}, i == 6 ? 8'h0c : 8'(2 * (i % 6)));
      end
      // A write while the clock enable is low must not land.
      i_bnkrf_core.acc(1, 8'hfd, 8'h0d);
      clk_en_i <= 1'b0;
      i_bnkrf_core.acc(1, 8'h08, 8'h5a);
      clk_en_i <= 1'b1;
      i_bnkrf_core.acc(0, 8'h08, v[8]);
      i_bnkrf_core.acc(1, 8'h08, 8'h5a);
      i_bnkrf_core.acc(0, 8'h08, 8'h5a);
      i_bnkrf_core.idle();
      // An ordinary reset clears even the registers that survive recovery.
      arst_n_i <= 1'b0;
      @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      @(posedge sys_clk_i);
      chk("p01 again", port0_port1_mode_o, 8'hcf);
      i_bnkrf_core.acc(1, 8'hfd, 8'h0d);
      i_bnkrf_core.acc(0, 8'h08, 8'h00);
      i_bnkrf_core.acc(0, 8'h03, 8'h1f);
      i_bnkrf_core.idle();
      results();
   end
endmodule
